// File: hdl/debug_signal_unit.sv
// Debug signal block: comms channel flags, debug request and entry,
// two watch units, instruction-executed and tracking mode, APB registers.
// Assumes one 200 MHz clock, inputs synchronous to it, zero-wait APB.
//
// How it works
// - comms_rx_full_o high while the receive word is unread by the core.
// - comms_tx_empty_o high while the transmit buffer holds nothing.
// - debug_state_ack_o high exactly while the core is in debug state.
// - Debug enable low disables debug entry; the system keeps it high.
// - Internal request combines external request with control bit 1.
// - External request halts the core at the next instruction boundary unless tracking mode is on.
// - External data watch input can trigger debug entry.
// - External instruction break input can trigger debug entry.
// - Condition inputs 0 and 1 feed watch units 0 and 1.
// - instr_executed_o pulses the cycle after a passed, executed instr.
// - Watch unit match outputs ignore the unit enable bit.
// - Tracking mode input held high puts the block into tracking mode.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "dbg_sig_cfg.svh"

module debug_signal_unit
   import dbg_sig_pkg::*;
#(
   parameter int NUM_WU = 2                      // Watch units.
)(
   input  wire logic        clk_i,                     // Core clock.
   input  wire logic        reset_n_i,                 // Async reset.
   input  wire logic        psel_i,                    // APB select.
   input  wire logic        penable_i,                 // APB enable.
   input  wire logic        pwrite_i,                  // APB write.
   input  wire logic [11:0] paddr_i,                   // APB address.
   input  wire logic [31:0] pwdata_i,                  // APB write data.
   output logic      [31:0] prdata_o,                  // APB read data.
   output logic             pready_o,                  // APB ready.
   output logic             pslverr_o,                 // APB error.
   input  wire core_bus_t   core_bus_i,                // Core bus.
   input  wire exec_report_t exec_i,                   // Execute report.
   input  wire logic        core_rx_read_i,            // Core reads rx.
   output logic      [31:0] core_rx_data_o,            // Rx word.
   input  wire logic        core_tx_write_i,           // Core writes tx.
   input  wire logic [31:0] core_tx_data_i,            // Tx word.
   input  wire logic        debug_features_enable_i,   // Debug enable.
   input  wire logic        external_debug_request_i,  // External request.
   input  wire logic        external_data_watch_i,     // External watch.
   input  wire logic        external_instr_break_i,    // External break.
   input  wire logic        watch_unit0_condition_i,   // Unit 0 condition.
   input  wire logic        watch_unit1_condition_i,   // Unit 1 condition.
   input  wire logic        tracking_mode_i,           // Tracking request.
   output logic             comms_rx_full_o,           // Rx unread.
   output logic             comms_tx_empty_o,          // Tx empty.
   output logic             debug_state_ack_o,         // In debug state.
   output logic             internal_debug_request_o,  // Request to core.
   output logic             instr_executed_o,          // Instr executed.
   output logic             watch_unit0_match_o,       // Unit 0 match.
   output logic             watch_unit1_match_o,       // Unit 1 match.
   output logic             core_halt_o,               // Stall core.
   output logic             tracking_active_o          // Tracking mode.
);

   // ============================================================
   // State
   dbg_state_t            state_r, state_nxt;
   logic                  req_bit_r, req_bit_nxt;
   logic [31:0]           rx_data_r, rx_data_nxt;
   logic                  rx_full_r, rx_full_nxt;
   logic [31:0]           tx_data_r, tx_data_nxt;
   logic                  tx_empty_r, tx_empty_nxt;
   logic [2:0]            cause_r, cause_nxt;
   logic [31:0]           prdata_r, prdata_nxt;
   logic                  pslverr_r, pslverr_nxt;
   logic                  int_req_r, int_req_nxt;
   logic                  exec_r, exec_nxt;
   logic [NUM_WU-1:0]     match_r, match_nxt;
   logic [31:0]           wu_addr_r  [NUM_WU];
   logic [31:0]           wu_addr_nxt [NUM_WU];
   logic [31:0]           wu_amask_r [NUM_WU];
   logic [31:0]           wu_amask_nxt [NUM_WU];
   logic [31:0]           wu_data_r  [NUM_WU];
   logic [31:0]           wu_data_nxt [NUM_WU];
   logic [`WU_CTRL_W-1:0] wu_ctrl_r  [NUM_WU];
   logic [`WU_CTRL_W-1:0] wu_ctrl_nxt [NUM_WU];

   logic [NUM_WU-1:0]     wu_cond;
   logic [NUM_WU-1:0]     wu_match;
   logic [NUM_WU-1:0]     wu_hit;
   logic                  setup_ph;
   logic                  access_ph;
   logic                  req_now;
   logic                  boundary;

   // ============================================================
   // Watch units
   assign wu_cond = {watch_unit1_condition_i, watch_unit0_condition_i};

   // The match is formed whether or not the unit is enabled, so that
   // external logic can chain units; only the hit is gated.
   for (genvar g = 0; g < NUM_WU; g++) begin : g_wu
      logic a_ok, d_ok, x_ok;
      assign a_ok = ((core_bus_i.addr ^ wu_addr_r[g]) & ~wu_amask_r[g])
                    == `RST_WORD;
      assign d_ok = !wu_ctrl_r[g][`WU_DCMP_BIT] ||
                    (core_bus_i.data == wu_data_r[g]);
      assign x_ok = !wu_ctrl_r[g][`WU_XUSE_BIT] ||
                    (wu_cond[g] == wu_ctrl_r[g][`WU_XVAL_BIT]);
      assign wu_match[g] = core_bus_i.valid && a_ok && d_ok && x_ok;
      assign wu_hit[g]   = wu_match[g] && wu_ctrl_r[g][`WU_EN_BIT];
   end

   // ============================================================
   // Bus phases and request
   assign setup_ph  = psel_i && !penable_i;
   assign access_ph = psel_i && penable_i;
   assign req_now   = external_debug_request_i || req_bit_r;
   assign boundary  = exec_i.done;

   // ============================================================
   // Next-state logic
   always_comb begin
      state_nxt   = state_r;
      req_bit_nxt = req_bit_r;
      rx_data_nxt = rx_data_r;
      rx_full_nxt = rx_full_r;
      tx_data_nxt = tx_data_r;
      tx_empty_nxt = tx_empty_r;
      cause_nxt   = cause_r;
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      for (int i = 0; i < NUM_WU; i++) begin
         wu_addr_nxt[i]  = wu_addr_r[i];
         wu_amask_nxt[i] = wu_amask_r[i];
         wu_data_nxt[i]  = wu_data_r[i];
         wu_ctrl_nxt[i]  = wu_ctrl_r[i];
      end
      int_req_nxt = req_now;
      exec_nxt    = exec_i.done && exec_i.cond_pass;
      match_nxt   = wu_match;

      // Core side of the comms channel: a core read clears, a core write
      // fills. Debugger accesses below are applied later so an rx fill wins; a taken core write keeps tx full.
      if (core_rx_read_i) begin
         rx_full_nxt = 1'b0;
      end
      if (tx_empty_r && core_tx_write_i) begin
         tx_data_nxt  = core_tx_data_i;
         tx_empty_nxt = 1'b0;
      end

      // Read data and error are staged in the setup cycle.
      if (setup_ph) begin
         prdata_nxt  = `RST_WORD;
         pslverr_nxt = 1'b0;
         if (paddr_i == `OFS_DBG_CTRL) begin
            prdata_nxt[`CTRL_REQ_BIT] = req_bit_r;
         end else if (paddr_i == `OFS_DBG_STATUS) begin
            prdata_nxt[`ST_DEBUG_BIT]   = (state_r == ST_HALT);
            prdata_nxt[`ST_ENABLE_BIT]  = debug_features_enable_i;
            prdata_nxt[`ST_TRACK_BIT]   = tracking_mode_i;
            prdata_nxt[`ST_RXFULL_BIT]  = rx_full_r;
            prdata_nxt[`ST_TXEMPTY_BIT] = tx_empty_r;
            prdata_nxt[`ST_CAUSE_WU_BIT:`ST_CAUSE_RQ_BIT] = cause_r;
         end else if (paddr_i == `OFS_COMMS_RX) begin
            prdata_nxt = rx_data_r;
         end else if (paddr_i == `OFS_COMMS_TX) begin
            prdata_nxt = tx_data_r;
         end else begin
            pslverr_nxt = 1'b1;
            for (int i = 0; i < NUM_WU; i++) begin
               if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                  + `WU_OFS_ADDR)) begin
                  prdata_nxt  = wu_addr_r[i];
                  pslverr_nxt = 1'b0;
               end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                         + `WU_OFS_AMASK)) begin
                  prdata_nxt  = wu_amask_r[i];
                  pslverr_nxt = 1'b0;
               end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                         + `WU_OFS_DATA)) begin
                  prdata_nxt  = wu_data_r[i];
                  pslverr_nxt = 1'b0;
               end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                         + `WU_OFS_CTRL)) begin
                  prdata_nxt[`WU_CTRL_W-1:0] = wu_ctrl_r[i];
                  pslverr_nxt = 1'b0;
               end
            end
         end
      end

      // Writes and read side effects take place at the access edge.
      if (access_ph && !pslverr_r) begin
         if (pwrite_i) begin
            if (paddr_i == `OFS_DBG_CTRL) begin
               req_bit_nxt = pwdata_i[`CTRL_REQ_BIT];
               if (pwdata_i[`CTRL_RESTART_BIT] && state_r == ST_HALT) begin
                  state_nxt = ST_RUN;
                  cause_nxt = 3'h0;
               end
            end else if (paddr_i == `OFS_COMMS_RX) begin
               rx_data_nxt = pwdata_i;
               rx_full_nxt = 1'b1;
            end else begin
               for (int i = 0; i < NUM_WU; i++) begin
                  if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                     + `WU_OFS_ADDR)) begin
                     wu_addr_nxt[i] = pwdata_i;
                  end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                            + `WU_OFS_AMASK)) begin
                     wu_amask_nxt[i] = pwdata_i;
                  end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                            + `WU_OFS_DATA)) begin
                     wu_data_nxt[i] = pwdata_i;
                  end else if (paddr_i == 12'(`OFS_WU_BASE + i * `WU_STRIDE
                                            + `WU_OFS_CTRL)) begin
                     wu_ctrl_nxt[i] = pwdata_i[`WU_CTRL_W-1:0];
                  end
               end
            end
         end else if (paddr_i == `OFS_COMMS_TX) begin
            // Only a core write taken in the same cycle keeps it full.
            tx_empty_nxt = !(tx_empty_r && core_tx_write_i);
         end
      end

      // Debug entry is only ever taken at an instruction boundary.
      case (state_r)
         ST_RUN: begin
            if (debug_features_enable_i && boundary &&
                (req_now || external_instr_break_i ||
                 external_data_watch_i || |wu_hit)) begin
               state_nxt = ST_HALT;
               cause_nxt = {external_data_watch_i || |wu_hit,
                            external_instr_break_i, req_now};
            end
         end
         ST_HALT: begin
            if (!debug_features_enable_i) begin
               state_nxt = ST_RUN;
               cause_nxt = 3'h0;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   // ============================================================
   // Registers
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r    <= ST_RUN;
         req_bit_r  <= 1'b0;
         rx_data_r  <= `RST_WORD;
         rx_full_r  <= 1'b0;
         tx_data_r  <= `RST_WORD;
         tx_empty_r <= 1'b1;
         cause_r    <= 3'h0;
         prdata_r   <= `RST_WORD;
         pslverr_r  <= 1'b0;
         int_req_r  <= 1'b0;
         exec_r     <= 1'b0;
         match_r    <= '0;
         for (int i = 0; i < NUM_WU; i++) begin
            wu_addr_r[i]  <= `RST_WORD;
            wu_amask_r[i] <= `RST_WORD;
            wu_data_r[i]  <= `RST_WORD;
            wu_ctrl_r[i]  <= `RST_WU_CTRL;
         end
      end else begin
         state_r    <= state_nxt;
         req_bit_r  <= req_bit_nxt;
         rx_data_r  <= rx_data_nxt;
         rx_full_r  <= rx_full_nxt;
         tx_data_r  <= tx_data_nxt;
         tx_empty_r <= tx_empty_nxt;
         cause_r    <= cause_nxt;
         prdata_r   <= prdata_nxt;
         pslverr_r  <= pslverr_nxt;
         int_req_r  <= int_req_nxt;
         exec_r     <= exec_nxt;
         match_r    <= match_nxt;
         for (int i = 0; i < NUM_WU; i++) begin
            wu_addr_r[i]  <= wu_addr_nxt[i];
            wu_amask_r[i] <= wu_amask_nxt[i];
            wu_data_r[i]  <= wu_data_nxt[i];
            wu_ctrl_r[i]  <= wu_ctrl_nxt[i];
         end
      end
   end

   // ============================================================
   // Outputs
   assign prdata_o                 = prdata_r;
   assign pready_o                 = 1'b1;
   assign pslverr_o                = pslverr_r && access_ph;
   assign core_rx_data_o           = rx_data_r;
   assign comms_rx_full_o          = rx_full_r;
   assign comms_tx_empty_o         = tx_empty_r;
   assign debug_state_ack_o        = (state_r == ST_HALT);
   assign internal_debug_request_o = int_req_r;
   assign instr_executed_o         = exec_r;
   assign watch_unit0_match_o      = match_r[0];
   assign watch_unit1_match_o      = match_r[1];
   // In tracking mode the core keeps running while debug state is shown.
   assign core_halt_o       = debug_state_ack_o && !tracking_mode_i;
   assign tracking_active_o = tracking_mode_i;

endmodule // debug_signal_unit

// File: hdl/dbg_sig_cfg.svh
// Register map, field positions and reset values of the debug signal block.
// Assumes it is included by bare name wherever these names are needed.
`ifndef DBG_SIG_CFG_SVH
`define DBG_SIG_CFG_SVH

// ============================================================
// Register offsets (byte addresses on APB)
`define OFS_DBG_CTRL     12'h000
`define OFS_DBG_STATUS   12'h004
`define OFS_COMMS_RX     12'h008
`define OFS_COMMS_TX     12'h00c
`define OFS_WU_BASE      12'h010
`define WU_STRIDE        12'h010
`define WU_OFS_ADDR      12'h000
`define WU_OFS_AMASK     12'h004
`define WU_OFS_DATA      12'h008
`define WU_OFS_CTRL      12'h00c

// ============================================================
// Field positions
`define CTRL_REQ_BIT     1
`define CTRL_RESTART_BIT 2
`define WU_EN_BIT        0
`define WU_DCMP_BIT      1
`define WU_XUSE_BIT      2
`define WU_XVAL_BIT      3
`define WU_CTRL_W        4
`define ST_DEBUG_BIT     0
`define ST_ENABLE_BIT    1
`define ST_TRACK_BIT     2
`define ST_RXFULL_BIT    3
`define ST_TXEMPTY_BIT   4
`define ST_CAUSE_RQ_BIT  5
`define ST_CAUSE_BK_BIT  6
`define ST_CAUSE_WU_BIT  7

// ============================================================
// Reset values
`define RST_WORD         32'h0000_0000
`define RST_WU_CTRL      4'h0

`endif

// File: hdl/dbg_sig_pkg.sv
// Types shared by the debug signal block and its bench.
// Assumes dbg_sig_cfg.svh supplies the register map.
package dbg_sig_pkg;

   // ============================================================
   // Debug state of the core, one-hot.
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,
      ST_HALT = 2'b10
   } dbg_state_t;

   // ============================================================
   // Core bus as seen by the watch units.
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic [31:0] data;
   } core_bus_t;

   // Per-instruction report from the execute stage.
   typedef struct packed {
      logic done;
      logic cond_pass;
   } exec_report_t;

endpackage

// File: test/dbg_sig_sva.sv
// Assertions on the debug signal block, bound to its top module.
// Assumes zero-wait APB and one-cycle flag latency at the block.
`timescale 1ns/1ps
`include "dbg_sig_cfg.svh"
module dbg_sig_sva
   import dbg_sig_pkg::*;
(
   input wire logic         clk_i,                    // Clock.
   input wire logic         reset_n_i,                // Reset.
   input wire logic         psel_i,                   // Select.
   input wire logic         penable_i,                // Access.
   input wire logic         pwrite_i,                 // Write.
   input wire logic  [11:0] paddr_i,                  // Address.
   input wire logic  [31:0] pwdata_i,                 // Data.
   input wire exec_report_t exec_i,                   // Boundary.
   input wire logic         core_rx_read_i,           // Rx read.
   input wire logic         core_tx_write_i,          // Tx write.
   input wire logic         debug_features_enable_i,  // Enable.
   input wire logic         external_debug_request_i, // Request.
   input wire logic         external_data_watch_i,    // Watch.
   input wire logic         external_instr_break_i,   // Break.
   input wire logic         tracking_mode_i,          // Tracking.
   input wire logic         comms_rx_full_o,          // Rx flag.
   input wire logic         comms_tx_empty_o,         // Tx flag.
   input wire logic         debug_state_ack_o,        // Ack.
   input wire logic         internal_debug_request_o, // Request out.
   input wire logic         instr_executed_o,         // Executed.
   input wire logic         core_halt_o,              // Halt.
   input wire logic         tracking_active_o         // Tracking out.
);
   // ============================================================
   // Decoded requests
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic wr_acc, rx_fill, restart;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign rx_fill = wr_acc && paddr_i == `OFS_COMMS_RX;
   assign restart = wr_acc && paddr_i == `OFS_DBG_CTRL
                    && pwdata_i[`CTRL_RESTART_BIT];
   // Entry needs a boundary, enable and one cause while running.
   sequence entry_s;
      exec_i.done && debug_features_enable_i && !debug_state_ack_o
      && (external_debug_request_i || external_instr_break_i
          || external_data_watch_i);
   endsequence
   sequence executed_s;
      exec_i.done && exec_i.cond_pass;
   endsequence
   rx_fill_a: assert property (rx_fill |=> comms_rx_full_o)
      else $error("rx flag not set by fill");
   rx_read_a: assert property (
      core_rx_read_i && !rx_fill |=> !comms_rx_full_o)
      else $error("rx flag not cleared by read");
   tx_fill_a: assert property (
      core_tx_write_i && comms_tx_empty_o |=> !comms_tx_empty_o)
      else $error("tx flag not cleared by write");
   halt_entry_a: assert property (entry_s |=> debug_state_ack_o)
      else $error("debug state not entered");
   ack_hold_a: assert property (
      debug_state_ack_o && debug_features_enable_i && !restart
      |=> debug_state_ack_o) else $error("ack dropped early");
   enable_gate_a: assert property (
      !debug_features_enable_i |=> !debug_state_ack_o)
      else $error("debug state while disabled");
   req_follow_a: assert property (
      external_debug_request_i |=> internal_debug_request_o)
      else $error("internal request missing");
   exec_pulse_a: assert property (executed_s |=> instr_executed_o)
      else $error("executed pulse missing");
   exec_cause_a: assert property (
      instr_executed_o |-> $past(exec_i.done && exec_i.cond_pass))
      else $error("executed pulse without cause");
   track_run_a: assert property (
      tracking_mode_i |-> tracking_active_o && !core_halt_o)
      else $error("tracking mode not honoured");
endmodule // dbg_sig_sva

bind debug_signal_unit dbg_sig_sva i_dbg_sig_sva (
   .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
   .exec_i, .core_rx_read_i, .core_tx_write_i, .debug_features_enable_i,
   .external_debug_request_i, .external_data_watch_i,
   .external_instr_break_i, .tracking_mode_i, .comms_rx_full_o,
   .comms_tx_empty_o, .debug_state_ack_o, .internal_debug_request_o,
   .instr_executed_o, .core_halt_o, .tracking_active_o);

// File: test/debug_glue_model.sv
// Model of the debug controller and glue logic beside the block.
// Assumes the bench commands halts and enable through two lines.
`timescale 1ns/1ps
module debug_glue_model (
   input  wire logic clk_i,                    // Clock.
   input  wire logic reset_n_i,                // Async reset.
   input  wire logic halt_cmd_i,               // Halt wanted.
   input  wire logic disable_cmd_i,            // Debug not wanted.
   input  wire logic debug_state_ack_i,        // Block halted.
   output logic      external_debug_request_o, // Request level.
   output logic      debug_features_enable_o   // Enable level.
);
   // ============================================================
   // Request
   // Held until the block answers, as entry waits for a boundary.
   logic req_r, req_nxt;
   always_comb begin
      req_nxt = halt_cmd_i && !debug_state_ack_i;
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         req_r <= 1'b0;
      else
         req_r <= req_nxt;
   end
   assign external_debug_request_o = req_r;
   assign debug_features_enable_o = !disable_cmd_i;
endmodule // debug_glue_model

// File: test/testbench.sv
// Bench for debug_signal_unit: APB master, core side, glue model.
// Assumes zero-wait APB and one-cycle flag latency at the block.
`timescale 1ns/1ps
`include "dbg_sig_cfg.svh"
module testbench
   import dbg_sig_pkg::*;
;
   logic         clk_i = 1'b0;
   logic         reset_n_i = 1'b0;
   logic         psel_i = 1'b0;
   logic         penable_i = 1'b0;
   logic         pwrite_i = 1'b0;
   logic  [11:0] paddr_i = 12'h000;
   logic  [31:0] pwdata_i = 32'h0, core_tx_data_i = 32'h0;
   core_bus_t    core_bus_i = '0;
   exec_report_t exec_i = '0;
   logic         core_rx_read_i = 1'b0, core_tx_write_i = 1'b0;
   logic         halt_cmd = 1'b0, disable_cmd = 1'b0, tracking_mode_i = 1'b0;
   logic         external_data_watch_i = 1'b0, external_instr_break_i = 1'b0;
   logic         watch_unit0_condition_i = 1'b0;
   logic         watch_unit1_condition_i = 1'b0;
   logic         debug_features_enable_i, external_debug_request_i, err;
   logic         pready_o, pslverr_o, comms_rx_full_o, comms_tx_empty_o;
   logic         debug_state_ack_o, internal_debug_request_o, instr_executed_o;
   logic         watch_unit0_match_o, watch_unit1_match_o, core_halt_o;
   logic         tracking_active_o;
   logic  [31:0] prdata_o, core_rx_data_o, rd, d, seed = 32'h15ee8;
   int           mismatches = 0, samples_checked = 0;
   typedef struct {int id; logic [31:0] exp;} note_t;
   note_t        notes[$];
   string        nm[12] = '{"prdata", "rx_data", "pslverr", "rx_full",
      "tx_empty", "ack", "int_req", "exec", "m0", "m1", "halt", "track"};
   wire    [9:0] flg = {tracking_active_o, core_halt_o, watch_unit1_match_o,
      watch_unit0_match_o, instr_executed_o, internal_debug_request_o,
      debug_state_ack_o, comms_tx_empty_o, comms_rx_full_o, err};
   always #2.5 clk_i = ~clk_i;
   debug_signal_unit i_debug_signal_unit (
      .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
      .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .core_bus_i, .exec_i,
      .core_rx_read_i, .core_rx_data_o, .core_tx_write_i, .core_tx_data_i,
      .debug_features_enable_i, .external_debug_request_i,
      .external_data_watch_i, .external_instr_break_i,
      .watch_unit0_condition_i, .watch_unit1_condition_i, .tracking_mode_i,
      .comms_rx_full_o, .comms_tx_empty_o, .debug_state_ack_o,
      .internal_debug_request_o, .instr_executed_o, .watch_unit0_match_o,
      .watch_unit1_match_o, .core_halt_o, .tracking_active_o);
   debug_glue_model i_debug_glue_model (
      .clk_i, .reset_n_i, .halt_cmd_i(halt_cmd), .disable_cmd_i(disable_cmd),
      .debug_state_ack_i(debug_state_ack_o),
      .external_debug_request_o(external_debug_request_i),
      .debug_features_enable_o(debug_features_enable_i));
   // ============================================================
   // Helpers and result watcher
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic note(input int id, input logic [31:0] v);
      notes.push_back('{id, v});
   endtask
   task automatic look();
      @(posedge clk_i);
      #1;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   always begin
      note_t n;
      logic [31:0] got;
      wait (notes.size() > 0);
      n = notes.pop_front();
      got = (n.id < 2) ? (n.id ? core_rx_data_o : rd) : 32'(flg[n.id-2]);
      samples_checked++;
      if (got !== n.exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", nm[n.id], n.exp, got);
      end
   end
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      #(20000 * 5);
      mismatches++;
      tally_and_finish();
   end
   // ============================================================
   // Scenarios
   initial begin
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      look();
      note(3, 0);
      note(4, 1);
      apb(1'b0, `OFS_DBG_STATUS, 32'h0);
      note(0, 32'h0000_0012);
      apb(1'b1, 12'h0fc, 32'hffff_ffff);
      note(2, 1);
      d = rnd();
      apb(1'b1, `OFS_COMMS_RX, d);
      look();
      note(3, 1);
      note(1, d);
      @(posedge clk_i);
      core_rx_read_i <= 1'b1;
      core_tx_write_i <= 1'b1;
      core_tx_data_i <= d;
      @(posedge clk_i);
      core_rx_read_i <= 1'b0;
      core_tx_data_i <= ~d;
      @(posedge clk_i);
      core_tx_write_i <= 1'b0;
      #1;
      note(3, 0);
      note(4, 0);
      apb(1'b0, `OFS_COMMS_TX, 32'h0);
      note(0, d);
      look();
      note(4, 1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `OFS_DBG_CTRL, {30'h0, k[1], 1'b0});
         @(posedge clk_i);
         halt_cmd <= k[0];
         repeat (3) @(posedge clk_i);
         #1;
         note(6, k[0] | k[1]);
      end
      apb(1'b1, `OFS_DBG_CTRL, 32'h0);
      disable_cmd <= 1'b1;
      exec_i <= '{done: 1'b1, cond_pass: 1'b1};
      repeat (3) @(posedge clk_i);
      #1;
      note(5, 0);
      @(posedge clk_i);
      disable_cmd <= 1'b0;
      halt_cmd <= 1'b0;
      exec_i <= '0;
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_i);
         halt_cmd <= (k == 0 || k == 3);
         external_instr_break_i <= (k == 1);
         external_data_watch_i <= (k == 2);
         tracking_mode_i <= (k == 3);
         repeat (2) @(posedge clk_i);
         exec_i <= '{done: 1'b1, cond_pass: 1'b0};
         @(posedge clk_i);
         exec_i <= '0;
         halt_cmd <= 1'b0;
         external_instr_break_i <= 1'b0;
         external_data_watch_i <= 1'b0;
         #1;
         note(5, 1);
         note(10, k != 3);
         note(11, k == 3);
         apb(1'b1, `OFS_DBG_CTRL, 32'h0000_0004);
         look();
         note(5, 0);
      end
      repeat (24) begin
         @(posedge clk_i);
         tracking_mode_i <= 1'b0;
         d = rnd();
         exec_i <= '{done: d[0], cond_pass: d[1]};
         look();
         note(7, d[0] & d[1]);
      end
      d = rnd();
      for (int u = 0; u < 2; u++) begin
         apb(1'b1, 12'(`OFS_WU_BASE + u * `WU_STRIDE), d);
         apb(1'b1, 12'(`OFS_WU_BASE + u * `WU_STRIDE + `WU_OFS_DATA), ~d);
         apb(1'b1, 12'(`OFS_WU_BASE + u * `WU_STRIDE + `WU_OFS_CTRL),
             {28'h0, 3'h7, u[0]});
      end
      for (int c = 0; c < 2; c++) begin
         @(posedge clk_i);
         exec_i <= '0;
         core_bus_i <= '{valid: 1'b1, addr: d, data: ~d};
         watch_unit0_condition_i <= c[0];
         watch_unit1_condition_i <= !c[0];
         repeat (2) @(posedge clk_i);
         #1;
         note(8, c[0]);
         note(9, !c[0]);
      end
      tally_and_finish();
   end
endmodule // testbench
